/* rtl/supply_reset_sequencer.sv */
// Supply start-up and reset chain: reference qualification, regulator enables, POR, reset merge, SPI reset view.
// Assumes comparator levels from analog monitors arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`include "supply_seq_cfg.svh"

// Overview of operation
// - Start reference only above minimum main level.
// - Assert reference_good after settle plus filter.
// - reference_good enables core and pre-driver regulators.
// - Core regulator stays off without reference_good.
// - Hold logic reset until core supply good.
// - Assert POR after sustained undervoltage plus delay.
// - core_reset_n is AND of three resets.
// - SPI module inactive while core reset asserted.
// - Command-word pattern differs while in reset.
// - Register reads return zero while in reset.
// - Core and SPI need only main supply.
// - Overvoltage disconnects main supply within 1 us; the code takes up to 2 synchroniser cycles plus OVD_CYC (25 cycles), 1.08 us.
// - Lower overvoltage shuts pre-driver regulator down.
module supply_reset_sequencer #(
  parameter int FILT_CYC = `REF_FILTER_CYC,
  parameter int PMIN_CYC = `POR_MIN_CYC,
  parameter int PDLY_CYC = `POR_DELAY_CYC,
  parameter int OVD_CYC  = `OV_DISC_CYC
) (
  // Clock and reset.
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  // Analog monitor levels, asynchronous.
  input  wire logic                      mainAboveRefMin,
  input  wire logic                      refSettled,
  input  wire logic                      coreSupplyLow,
  input  wire logic                      mainOverVolt,
  input  wire logic                      mainOverVoltPre,
  // Reset sources.
  input  wire logic                      ext_reset_n,
  input  wire logic                      spi_soft_reset_n,
  // SPI answer path from the register logic.
  input  wire logic [7:0]                spiCmdPattern,
  input  wire logic [15:0]               spiReadData,
  // Supply control outputs.
  output logic                           refEnable,
  output logic                           reference_good,
  output logic                           coreRegEnable,
  output logic                           preRegEnable,
  output logic                           mainConnect,
  // Reset outputs.
  output logic                           supply_por_n,
  output logic                           core_reset_n,
  output logic                           spiActive,
  // SPI answer to the host.
  output logic [7:0]                     misoCmdWord,
  output logic [15:0]                    misoReadData
);
  import supply_seq_pkg::*;

  // Refuses counts that the 16-bit timers cannot hold, at elaboration.
  if (FILT_CYC < 1 || PMIN_CYC < 1 || PDLY_CYC < 1 || OVD_CYC < 1 || FILT_CYC > 65535 ||
      OVD_CYC > 65535 || PMIN_CYC + PDLY_CYC > 65535) begin : g_badCounts
    $error("supply_reset_sequencer: counts out of range");
  end

  // Two-stage synchronisers for all asynchronous levels.
  logic [6:0] syncA_r, syncB_r, syncA_nxt, syncB_nxt;
  always_comb begin
    syncA_nxt = {mainAboveRefMin, refSettled, coreSupplyLow, mainOverVolt, mainOverVoltPre,
                 ext_reset_n, spi_soft_reset_n};
    syncB_nxt = syncA_r;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      syncA_r <= 7'h03;
      syncB_r <= 7'h03;
    end else begin
      syncA_r <= syncA_nxt;
      syncB_r <= syncB_nxt;
    end
  end
  logic mainOk, refOk, coreLow, ovHigh, ovPre, extRstN, spiRstN;
  assign {mainOk, refOk, coreLow, ovHigh, ovPre, extRstN, spiRstN} = syncB_r;

  // Saturating count step shared by all timers.
  function automatic logic [15:0] countUp(input logic [15:0] c, input logic run);
    countUp = !run ? 16'h0000 : ((c == 16'hFFFF) ? c : c + 16'h0001);
  endfunction

  // Reference start and qualification sequence.
  seq_state_t state_r, state_nxt;
  logic [15:0] filtCnt_r, filtCnt_nxt;
  always_comb begin
    state_nxt   = state_r;
    filtCnt_nxt = 16'h0000;
    case (state_r)
      SEQ_OFF:    if (mainOk) state_nxt = SEQ_FILTER;
      SEQ_FILTER: begin
        filtCnt_nxt = countUp(filtCnt_r, refOk);
        if (!mainOk) state_nxt = SEQ_OFF;
        else if (refOk && filtCnt_r >= 16'(FILT_CYC - 1)) state_nxt = SEQ_CORE;
      end
      SEQ_CORE:   if (!mainOk) state_nxt = SEQ_OFF;
      SEQ_RUN:    if (!mainOk) state_nxt = SEQ_OFF;
      default:    state_nxt = SEQ_OFF;
    endcase
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r   <= SEQ_OFF;
      filtCnt_r <= 16'h0000;
    end else begin
      state_r   <= state_nxt;
      filtCnt_r <= filtCnt_nxt;
    end
  end

  // Power-on reset: sustained undervoltage, then assertion delay; also the overvoltage disconnect timer.
  logic [15:0] lowCnt_r, lowCnt_nxt, dlyCnt_r, dlyCnt_nxt;
  logic        por_r, por_nxt, ovDisc_r, ovDisc_nxt;
  logic [15:0] ovCnt_r, ovCnt_nxt;
  always_comb begin
    lowCnt_nxt = countUp(lowCnt_r, coreLow);
    dlyCnt_nxt = countUp(dlyCnt_r, coreLow && lowCnt_r >= 16'(PMIN_CYC));
    por_nxt    = por_r;
    if (!reference_good) por_nxt = 1'b0;
    else if (coreLow && dlyCnt_r >= 16'(PDLY_CYC)) por_nxt = 1'b0;
    else if (!coreLow) por_nxt = 1'b1;
    ovCnt_nxt  = countUp(ovCnt_r, ovHigh);
    ovDisc_nxt = ovHigh && (ovCnt_r >= 16'(OVD_CYC - 1));
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lowCnt_r <= 16'h0000;
      dlyCnt_r <= 16'h0000;
      por_r    <= 1'b0;
      ovCnt_r  <= 16'h0000;
      ovDisc_r <= 1'b0;
    end else begin
      lowCnt_r <= lowCnt_nxt;
      dlyCnt_r <= dlyCnt_nxt;
      por_r    <= por_nxt;
      ovCnt_r  <= ovCnt_nxt;
      ovDisc_r <= ovDisc_nxt;
    end
  end

  // Supply enables follow the sequence state, preRegEnable also gated by overvoltage; mainConnect follows the disconnect timer only.
  assign refEnable      = (state_r != SEQ_OFF);
  assign reference_good = (state_r == SEQ_CORE) || (state_r == SEQ_RUN);
  assign coreRegEnable  = reference_good;
  assign preRegEnable   = reference_good && !ovPre && !ovDisc_r;
  assign mainConnect    = !ovDisc_r;
  assign supply_por_n   = por_r;
  assign core_reset_n   = por_r & extRstN & spiRstN;
  assign spiActive      = core_reset_n;

  // SPI answer words, masked while in reset.
  logic [7:0]  cmdWord_r, cmdWord_nxt;
  logic [15:0] rdData_r, rdData_nxt;
  always_comb begin
    cmdWord_nxt = core_reset_n ? spiCmdPattern : `RESET_PATTERN;
    rdData_nxt  = core_reset_n ? spiReadData : 16'h0000;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmdWord_r <= `RESET_PATTERN;
      rdData_r  <= 16'h0000;
    end else begin
      cmdWord_r <= cmdWord_nxt;
      rdData_r  <= rdData_nxt;
    end
  end
  assign misoCmdWord  = cmdWord_r;
  assign misoReadData = rdData_r;

  // Assertion helper: counts consecutive cycles of synchronised core undervoltage.
  logic [15:0] lowRun_r, lowRun_nxt;
  always_comb begin
    lowRun_nxt = countUp(lowRun_r, coreLow);
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lowRun_r <= 16'h0000;
    end else begin
      lowRun_r <= lowRun_nxt;
    end
  end

  // Assertions.
  // Undervoltage has lasted the minimum duration plus the assertion delay.
  sequence s_lowLong;
    coreLow && (lowRun_r >= 16'(PMIN_CYC + PDLY_CYC));
  endsequence
  // Eight cycles of overvoltage in a row.
  sequence s_ovHeld8;
    ovHigh [*8];
  endsequence

  chk_ref_start: assert property (@(posedge core_clk) disable iff (!nrst)
    !mainOk |=> !reference_good) else $error("reference good without main supply");
  chk_ref_main: assert property (@(posedge core_clk) disable iff (!nrst)
    refEnable |-> $past(mainOk)) else $error("reference started without main supply");
  chk_ref_filter: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(reference_good) |-> filtCnt_r >= 16'(FILT_CYC - 1)) else $error("filter cut short");
  chk_core_enable: assert property (@(posedge core_clk) disable iff (!nrst)
    coreRegEnable == reference_good) else $error("core regulator enable wrong");
  chk_core_off: assert property (@(posedge core_clk) disable iff (!nrst)
    !reference_good |-> !coreRegEnable && !preRegEnable) else $error("regulator on early");
  chk_por_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    !reference_good |=> !supply_por_n) else $error("por released before supply");
  chk_por_release: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(supply_por_n) |-> !$past(coreLow) && $past(reference_good))
    else $error("por released while core low");
  chk_por_assert: assert property (@(posedge core_clk) disable iff (!nrst)
    s_lowLong |=> !supply_por_n) else $error("por not asserted");
  chk_por_early: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(supply_por_n) && $past(reference_good) |-> $past(lowRun_r) >= 16'(PMIN_CYC + PDLY_CYC))
    else $error("por asserted too early");
  chk_reset_and: assert property (@(posedge core_clk) disable iff (!nrst)
    core_reset_n == (supply_por_n && extRstN && spiRstN)) else $error("reset merge wrong");
  chk_spi_idle: assert property (@(posedge core_clk) disable iff (!nrst)
    !core_reset_n |-> !spiActive) else $error("spi active in reset");
  chk_cmd_mask: assert property (@(posedge core_clk) disable iff (!nrst)
    !core_reset_n |=> misoCmdWord != `CTRL_PATTERN) else $error("pattern during reset");
  chk_read_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    !core_reset_n |=> misoReadData == 16'h0000) else $error("read data in reset");
  chk_ov_disc: assert property (@(posedge core_clk) disable iff (!nrst)
    s_ovHeld8 ##1 s_ovHeld8 ##1 s_ovHeld8 ##1 ovHigh |=> !mainConnect)
    else $error("overvoltage disconnect late");
  chk_pre_ov: assert property (@(posedge core_clk) disable iff (!nrst)
    ovPre |-> !preRegEnable) else $error("pre-driver on in overvoltage");
endmodule // supply_reset_sequencer

/* rtl/supply_seq_cfg.svh */
// Timing constants of the supply start-up and reset sequencer.
// Assumes a 25 MHz core clock; included by its bare name.
`ifndef SUPPLY_SEQ_CFG_SVH
`define SUPPLY_SEQ_CFG_SVH
`define CLK_PERIOD_NS      40
`define REF_FILTER_NS      9000
`define REF_FILTER_CYC     (`REF_FILTER_NS / `CLK_PERIOD_NS)
`define POR_MIN_NS         361
`define POR_MIN_CYC        ((`POR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POR_DELAY_NS       700
`define POR_DELAY_CYC      (`POR_DELAY_NS / `CLK_PERIOD_NS)
`define OV_DISC_NS         1000
`define OV_DISC_CYC        (`OV_DISC_NS / `CLK_PERIOD_NS)
`define CTRL_PATTERN       8'hA8
`define RESET_PATTERN      8'h00
`endif

/* rtl/supply_seq_pkg.sv */
// Types shared by the supply sequencer.
// Holds no constants; those live in the cfg header.
package supply_seq_pkg;
  typedef enum logic [3:0] {
    SEQ_OFF    = 4'b0001,
    SEQ_FILTER = 4'b0010,
    SEQ_CORE   = 4'b0100,
    SEQ_RUN    = 4'b1000
  } seq_state_t;
endpackage

/* testbench/host_model.sv */
// Host model: drives the reset pin and the soft reset, and polls the command-word pattern.
// Assumes the device answers on misoCmdWord in the core_clk domain.
`timescale 1ns/1ps
module host_model (
  // Clock and requests from the bench.
  input  wire logic       core_clk,
  input  wire logic       pinLow,
  input  wire logic       softReq,
  input  wire logic [7:0] misoCmdWord,
  // Reset lines and poll result.
  output logic            ext_reset_n,
  output logic            spi_soft_reset_n,
  output logic            hostReady
);
  // Reset lines change just after an edge; ready only once the pattern is seen with the pins released.
  always_ff @(posedge core_clk) begin
    ext_reset_n      <= !pinLow;
    spi_soft_reset_n <= !softReq;
    hostReady        <= (misoCmdWord === 8'hA8) && !pinLow && !softReq;
  end
endmodule // host_model

/* testbench/tb_supply_reset_sequencer.sv */
// Self-checking bench for the supply sequencer with a host model on the reset lines.
// Assumes the design package, the cfg header and host_model are compiled first.
`timescale 1ns/1ps
module tb_supply_reset_sequencer;
  import supply_seq_pkg::*;
  localparam int FC = 4, PM = 2, PD = 2, OV = 3;
  logic core_clk = 0, nrst = 0, mainAboveRefMin = 0, refSettled = 0, coreSupplyLow = 0;
  logic mainOverVolt = 0, mainOverVoltPre = 0, pinLow = 0, softReq = 0;
  logic ext_reset_n, spi_soft_reset_n, hostReady, refEnable, reference_good, coreRegEnable;
  logic preRegEnable, mainConnect, supply_por_n, core_reset_n, spiActive;
  logic [7:0] spiCmdPattern = 8'hA8, misoCmdWord;
  logic [15:0] spiReadData = 16'h0000, misoReadData;
  int miscompares = 0, nTests = 0, seed = 63, n;
  // Model of the read path: every word offered is expected back in order.
  logic [15:0] rnd;
  logic [15:0] expQ[$];
  wire [3:0] mon = {reference_good, supply_por_n, mainConnect, preRegEnable};

  supply_reset_sequencer #(.FILT_CYC(FC), .PMIN_CYC(PM), .PDLY_CYC(PD), .OVD_CYC(OV)) i_supply_reset_sequencer (
    .core_clk(core_clk), .nrst(nrst), .mainAboveRefMin(mainAboveRefMin), .refSettled(refSettled),
    .coreSupplyLow(coreSupplyLow), .mainOverVolt(mainOverVolt), .mainOverVoltPre(mainOverVoltPre),
    .ext_reset_n(ext_reset_n), .spi_soft_reset_n(spi_soft_reset_n), .spiCmdPattern(spiCmdPattern),
    .spiReadData(spiReadData), .refEnable(refEnable), .reference_good(reference_good),
    .coreRegEnable(coreRegEnable), .preRegEnable(preRegEnable), .mainConnect(mainConnect),
    .supply_por_n(supply_por_n), .core_reset_n(core_reset_n), .spiActive(spiActive),
    .misoCmdWord(misoCmdWord), .misoReadData(misoReadData));
  host_model i_host_model (.core_clk(core_clk), .pinLow(pinLow), .softReq(softReq),
    .misoCmdWord(misoCmdWord), .ext_reset_n(ext_reset_n), .spi_soft_reset_n(spi_soft_reset_n),
    .hostReady(hostReady));

  // Compares one result with the model's value and counts it.
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waits a bounded time for one monitored output to reach a level; n holds the cycles taken.
  task automatic waitBit(int idx, logic val);
    n = 0;
    #1;
    while (mon[idx] !== val && n < 400) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Free-running 25 MHz clock.
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    #(40 * 5000);
    miscompares++;
    wrap_up();
  end
  // Main sequence of scenarios.
  initial begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    #1;
    check("regOffAtStart", {coreRegEnable, reference_good, supply_por_n, mainConnect}, 16'h0001);
    check("cmdInReset", misoCmdWord, 16'h0000);
    @(posedge core_clk);
    mainAboveRefMin <= 1'b1;
    refSettled      <= 1'b1;
    waitBit(3, 1'b1);
    check("refGoodLatency", (n >= FC + 2 && n <= FC + 6), 16'h0001);
    check("regEnables", {refEnable, coreRegEnable, preRegEnable}, 16'h0007);
    $display("test reference start done");
    waitBit(2, 1'b1);
    repeat (3) @(posedge core_clk);
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      rnd = 16'($random(seed));
      spiReadData <= rnd;
      expQ.push_back(rnd);
      repeat (2) @(posedge core_clk);
      #1;
      check("readData", misoReadData, expQ.pop_front());
      check("cmdPattern", {misoCmdWord, 7'h00, core_reset_n & spiActive & hostReady}, 16'hA801);
    end
    $display("test run state done");
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      pinLow      <= (k == 0);
      softReq     <= (k == 1);
      spiReadData <= 16'hFFFF;
      repeat (5) @(posedge core_clk);
      #1;
      check("mergedReset", {core_reset_n, spiActive, misoCmdWord == 8'hA8}, 16'h0000);
      check("zeroRead", {misoReadData[15:8] | misoReadData[7:0], misoCmdWord}, 16'h0000);
      @(posedge core_clk);
      pinLow  <= 1'b0;
      softReq <= 1'b0;
      repeat (5) @(posedge core_clk);
      #1;
      check("resetRelease", {core_reset_n, misoCmdWord}, 16'h01A8);
    end
    $display("test reset merge done");
    @(posedge core_clk);
    coreSupplyLow <= 1'b1;
    waitBit(2, 1'b0);
    check("porLatency", (n >= PM + PD + 1 && n <= PM + PD + 6), 16'h0001);
    check("resetFromPor", core_reset_n, 16'h0000);
    @(posedge core_clk);
    coreSupplyLow <= 1'b0;
    waitBit(2, 1'b1);
    check("porRelease", (n <= 6), 16'h0001);
    $display("test power-on reset done");
    @(posedge core_clk);
    mainOverVoltPre <= 1'b1;
    waitBit(0, 1'b0);
    check("preRegOff", (n <= 5) & mainConnect, 16'h0001);
    @(posedge core_clk);
    mainOverVolt <= 1'b1;
    waitBit(1, 1'b0);
    check("disconnectLatency", (n >= OV + 1 && n <= OV + 6), 16'h0001);
    repeat (30) @(posedge core_clk);
    #1;
    check("disconnectHeld", {mainConnect, preRegEnable}, 16'h0000);
    @(posedge core_clk);
    mainOverVolt    <= 1'b0;
    mainOverVoltPre <= 1'b0;
    waitBit(1, 1'b1);
    waitBit(0, 1'b1);
    check("reconnect", {mainConnect, preRegEnable}, 16'h0003);
    $display("test overvoltage done");
    @(posedge core_clk);
    mainAboveRefMin <= 1'b0;
    waitBit(3, 1'b0);
    repeat (2) @(posedge core_clk);
    #1;
    check("mainLost", {coreRegEnable, supply_por_n, refEnable}, 16'h0000);
    $display("test main loss done");
    wrap_up();
  end
endmodule // tb_supply_reset_sequencer
